// [pdac_host_ctrl.sv]
// Host controller driving the converter parallel port pins
// Functional notes
// - Read/write select steady through whole access
// - Access lives only while chip select low
// - Busy low after write; wait high
// - Same address writes need 30ns spacing
`timescale 1ns/1ps
module pdac_host_ctrl
   import pdac_host_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_req_valid,
   input wire host_req_s i_req,
   input wire logic i_sync_mode,
   input wire logic i_load_req,
   input wire logic [DATA_W-1:0] i_data_in,
   input wire logic i_busy_n,
   output logic o_req_ready,
   output logic o_rd_valid,
   output logic [DATA_W-1:0] o_rd_data,
   output logic o_cs_n,
   output logic o_rd_wr_n,
   output logic [ADDR_W-1:0] o_addr,
   output logic [DATA_W-1:0] o_data_out,
   output logic o_data_oe,
   output logic o_output_load_strobe_n,
   output logic o_load_done
);
   typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_ACTIVE, ST_HOLD, ST_LOAD_WAIT, ST_LOAD, ST_LOAD_REC} state_e;

   state_e state_ff, nxt_state;
   logic [CNT_W-1:0] cnt_ff, nxt_cnt;
   logic [CNT_W-1:0] gap_ff, nxt_gap;
   logic [CNT_W-1:0] settle_ff, nxt_settle;
   logic [ADDR_W-1:0] last_addr_ff;
   logic [ADDR_W-1:0] nxt_last_addr;
   logic wrote_ff, nxt_wrote;
   logic load_pend_ff, nxt_load_pend;
   logic [DATA_W-1:0] din_s1_ff, din_s2_ff;
   logic busy_s1_ff, busy_s2_ff;
   logic cs_n_ff, rw_ff, oe_ff, ld_n_ff, ready_ff, rvalid_ff, ldone_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic [DATA_W-1:0] dout_ff, rdata_ff;
   logic nxt_cs_n, nxt_rw, nxt_oe, nxt_ld_n, nxt_ready, nxt_rvalid, nxt_ldone;
   logic [ADDR_W-1:0] nxt_addr;
   logic [DATA_W-1:0] nxt_dout, nxt_rdata;

   // Pin inputs pass two flops before use
   always_ff @(posedge i_ref_clk) begin
      busy_s1_ff <= i_busy_n;
      busy_s2_ff <= busy_s1_ff;
      din_s1_ff <= i_data_in;
      din_s2_ff <= din_s1_ff;
   end

   // Counts share CNT_W-bit counters; one that does not fit would wrap and cut a phase short
   localparam int CNT_MAX = 2 ** CNT_W - 1;
   if (CS_RD_CYC > CNT_MAX || CS_WR_CYC > CNT_MAX || GAP_CYC > CNT_MAX || BUSY_SETTLE_CYC > CNT_MAX ||
      CS_TO_LOAD_CYC > CNT_MAX || LOAD_CYC > CNT_MAX || LOAD_TO_CS_CYC > CNT_MAX) begin : gen_count_check
      $error("Host controller timing count exceeds the counter width");
   end

   // Same-address writes must wait out the spacing counter
   wire same_addr_block = i_req.wr && wrote_ff && (i_req.addr == last_addr_ff) && (gap_ff != '0);
   // Busy high means correction and prior update are finished; just after a write the
   // synchronised copy is still stale, so the settle count holds off until busy is seen low
   wire busy_clear = busy_s2_ff && (settle_ff == '0);
   wire take_req = (state_ff == ST_IDLE) && i_req_valid && !same_addr_block && busy_clear && !load_pend_ff;
   wire start_load = (state_ff == ST_IDLE) && load_pend_ff && busy_clear && (gap_ff == '0);

   // Sequencer for one access or one load strobe
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_gap = (gap_ff != '0) ? gap_ff - 1'b1 : gap_ff;
      nxt_settle = (settle_ff != '0) ? settle_ff - 1'b1 : settle_ff;
      nxt_last_addr = last_addr_ff;
      nxt_wrote = wrote_ff;
      nxt_load_pend = load_pend_ff | (i_load_req & i_sync_mode);
      nxt_cs_n = cs_n_ff;
      nxt_rw = rw_ff;
      nxt_oe = oe_ff;
      nxt_ld_n = ld_n_ff;
      nxt_addr = addr_ff;
      nxt_dout = dout_ff;
      nxt_rdata = rdata_ff;
      nxt_rvalid = 1'b0;
      nxt_ldone = 1'b0;
      nxt_ready = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            // Async mode keeps the load pin low so writes land directly
            nxt_ld_n = !i_sync_mode ? 1'b0 : 1'b1;
            if (start_load) begin
               nxt_load_pend = 1'b0;
               nxt_cnt = CNT_W'(CS_TO_LOAD_CYC);
               nxt_state = ST_LOAD_WAIT;
            end else if (take_req) begin
               // Select and address set one cycle before chip select
               nxt_rw = !i_req.wr;
               nxt_addr = i_req.addr;
               nxt_dout = i_req.data;
               nxt_oe = i_req.wr;
               nxt_state = ST_SETUP;
            end else begin
               nxt_ready = !load_pend_ff;
            end
         end
         ST_SETUP: begin
            nxt_cs_n = 1'b0;
            nxt_cnt = rw_ff ? CNT_W'(CS_RD_CYC) : CNT_W'(CS_WR_CYC);
            nxt_state = ST_ACTIVE;
         end
         ST_ACTIVE: begin
            if (cnt_ff > CNT_W'(1)) begin
               nxt_cnt = cnt_ff - 1'b1;
            end else begin
               // Rising edge latches address and data in the device
               nxt_cs_n = 1'b1;
               if (rw_ff) begin
                  nxt_rdata = din_s2_ff;
                  nxt_rvalid = 1'b1;
               end else begin
                  nxt_wrote = 1'b1;
                  nxt_last_addr = addr_ff;
                  nxt_gap = CNT_W'(GAP_CYC);
                  nxt_settle = CNT_W'(BUSY_SETTLE_CYC);
               end
               nxt_state = ST_HOLD;
            end
         end
         ST_HOLD: begin
            // Data and select held one cycle past the rise
            nxt_oe = 1'b0;
            nxt_rw = 1'b1;
            nxt_state = ST_IDLE;
         end
         ST_LOAD_WAIT: begin
            if (cnt_ff > CNT_W'(1)) begin
               nxt_cnt = cnt_ff - 1'b1;
            end else begin
               nxt_ld_n = 1'b0;
               nxt_cnt = CNT_W'(LOAD_CYC);
               nxt_state = ST_LOAD;
            end
         end
         ST_LOAD: begin
            if (cnt_ff > CNT_W'(1)) begin
               nxt_cnt = cnt_ff - 1'b1;
            end else begin
               nxt_ld_n = 1'b1;
               nxt_cnt = CNT_W'(LOAD_TO_CS_CYC);
               nxt_state = ST_LOAD_REC;
            end
         end
         ST_LOAD_REC: begin
            if (cnt_ff > CNT_W'(1)) begin
               nxt_cnt = cnt_ff - 1'b1;
            end else begin
               nxt_ldone = 1'b1;
               nxt_state = ST_IDLE;
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   // State and pin registers; reset leaves the bus idle
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         state_ff <= ST_IDLE;
         cnt_ff <= '0;
         gap_ff <= '0;
         settle_ff <= '0;
         last_addr_ff <= '0;
         wrote_ff <= 1'b0;
         load_pend_ff <= 1'b0;
         cs_n_ff <= 1'b1;
         rw_ff <= 1'b1;
         oe_ff <= 1'b0;
         ld_n_ff <= 1'b1;
         addr_ff <= '0;
         dout_ff <= '0;
         rdata_ff <= '0;
         rvalid_ff <= 1'b0;
         ldone_ff <= 1'b0;
         ready_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         gap_ff <= nxt_gap;
         settle_ff <= nxt_settle;
         last_addr_ff <= nxt_last_addr;
         wrote_ff <= nxt_wrote;
         load_pend_ff <= nxt_load_pend;
         cs_n_ff <= nxt_cs_n;
         rw_ff <= nxt_rw;
         oe_ff <= nxt_oe;
         ld_n_ff <= nxt_ld_n;
         addr_ff <= nxt_addr;
         dout_ff <= nxt_dout;
         rdata_ff <= nxt_rdata;
         rvalid_ff <= nxt_rvalid;
         ldone_ff <= nxt_ldone;
         ready_ff <= nxt_ready;
      end
   end

   // Outputs straight from flops
   assign o_cs_n = cs_n_ff;
   assign o_rd_wr_n = rw_ff;
   assign o_addr = addr_ff;
   assign o_data_out = dout_ff;
   assign o_data_oe = oe_ff;
   assign o_output_load_strobe_n = ld_n_ff;
   assign o_rd_data = rdata_ff;
   assign o_rd_valid = rvalid_ff;
   assign o_load_done = ldone_ff;
   assign o_req_ready = ready_ff;
endmodule

// [pdac_host_pkg.sv]
// Package for the parallel converter host port controller
package pdac_host_pkg;
   // Bus widths
   localparam int ADDR_W = 5;
   localparam int DATA_W = 14;
   // Clock period and derived counts
   localparam int CLK_PERIOD_NS = 40;
   localparam int CS_WR_WIDTH_NS = 15;
   localparam int CS_RD_WIDTH_NS = 30;
   localparam int RD_DATA_VALID_NS = 25;
   localparam int SAME_ADDR_GAP_NS = 30;
   localparam int CS_TO_LOAD_NS = 30;
   localparam int LOAD_WIDTH_NS = 10;
   localparam int LOAD_TO_CS_NS = 20;
   localparam int CS_TO_BUSY_NS = 20;
   localparam int CS_WR_CYC = (CS_WR_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RD_WAIT_CYC = (RD_DATA_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;
   localparam int CS_RD_CYC = (RD_WAIT_CYC > CS_RD_WIDTH_NS / CLK_PERIOD_NS) ? RD_WAIT_CYC : 1;
   localparam int GAP_CYC = (SAME_ADDR_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CS_TO_LOAD_CYC = (CS_TO_LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOAD_CYC = (LOAD_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOAD_TO_CS_CYC = (LOAD_TO_CS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Busy may fall this late after a write; the extra cycle covers the synchroniser
   localparam int BUSY_SETTLE_CYC = (CS_TO_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
   localparam int CNT_W = 4;
   // Request carried from the user side
   typedef struct packed {
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } host_req_s;
endpackage

// [pdac_host_properties.sv]
// Pin timing checks for the host controller
`timescale 1ns/1ps
module pdac_host_properties (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_sync_mode,
   input wire logic i_busy_n,
   input wire logic o_cs_n,
   input wire logic o_rd_wr_n,
   input wire logic o_output_load_strobe_n,
   input wire logic o_rd_valid
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   // A read holds select three cycles and hands data over as select rises
   sequence rd_hold;
      !o_cs_n [*3] ##1 (o_cs_n && o_rd_valid);
   endsequence
   // The gap keeps busy visible before any strobe or new select
   chk_rw_steady: assert property (!o_cs_n |-> $stable(o_rd_wr_n)) else $error("direction moved");
   chk_read_width: assert property ($fell(o_cs_n) && o_rd_wr_n |-> rd_hold) else $error("read width");
   chk_load_spacing: assert property ($rose(o_cs_n) && !o_rd_wr_n && i_sync_mode |-> o_output_load_strobe_n [*2])
      else $error("load too soon");
   chk_cs_gap: assert property ($rose(o_cs_n) |-> o_cs_n [*3]) else $error("select gap");
   // A strobe that lands inside busy would be deferred or lost by the part
   chk_load_after_busy: assert property ($fell(o_output_load_strobe_n) && i_sync_mode |-> i_busy_n)
      else $error("strobe while busy");
endmodule
bind pdac_host_ctrl pdac_host_properties chk (.i_ref_clk, .i_rst_n, .i_sync_mode, .i_busy_n, .o_cs_n,
   .o_rd_wr_n, .o_output_load_strobe_n, .o_rd_valid);

// [pdac_dev_model.sv]
// Behavioural model of the converter parallel port
`timescale 1ns/1ps
module pdac_dev_model
   import pdac_host_pkg::*;
#(parameter int BUSY_NS = 200) (
   input wire logic i_cs_n,
   input wire logic i_rw_n,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_bus,
   input wire logic i_ld_n,
   output logic o_busy_n = 1'b1,
   output logic o_oe,
   output logic [DATA_W-1:0] o_bus,
   output logic [DATA_W-1:0] o_out = '0
);
   logic [DATA_W-1:0] mem [32];
   logic [DATA_W-1:0] hold = '0;
   // Drives only while selected for reading; lags select as a slow part would
   assign #20 o_oe = !i_cs_n && i_rw_n;
   assign o_bus = mem[i_addr];
   // Write taken at the select rise; busy follows within 20 ns
   always @(posedge i_cs_n) begin
      if (!i_rw_n) begin
         mem[i_addr] = i_bus;
         hold = i_bus;
         if (!i_ld_n) o_out = i_bus;
         // Busy covers the correction pass that the write starts
         o_busy_n <= #10 1'b0;
         o_busy_n <= #(10 + BUSY_NS) 1'b1;
      end
   end
   // Strobe moves the held word to the output, but not before correction ends
   always @(negedge i_ld_n) begin
      wait (o_busy_n);
      o_out = hold;
   end
endmodule

// [testbench.sv]
// Testbench of the host controller against the converter model
`timescale 1ns/1ps
module testbench;
   import pdac_host_pkg::*;
   logic i_ref_clk = 1'b0, i_rst_n = 1'b0, i_req_valid = 1'b0, i_sync_mode = 1'b0, i_load_req = 1'b0;
   logic i_busy_n, o_rd_valid, o_cs_n, o_rd_wr_n, o_data_oe, o_output_load_strobe_n, o_load_done, d_oe;
   logic o_req_ready;
   logic [ADDR_W-1:0] o_addr;
   logic [DATA_W-1:0] i_data_in, o_rd_data, o_data_out, d_bus, q;
   host_req_s i_req = '0;
   int num_errors = 0, n_tests = 0;
   // Resolved bus; idle it shows the inverse so stale data cannot pass
   assign i_data_in = o_data_oe ? o_data_out : (d_oe ? d_bus : ~d_bus);
   pdac_host_ctrl dut (.i_ref_clk, .i_rst_n, .i_req_valid, .i_req, .i_sync_mode, .i_load_req, .i_data_in,
      .i_busy_n, .o_req_ready, .o_rd_valid, .o_rd_data, .o_cs_n, .o_rd_wr_n, .o_addr, .o_data_out,
      .o_data_oe, .o_output_load_strobe_n, .o_load_done);
   pdac_dev_model dev (.i_cs_n(o_cs_n), .i_rw_n(o_rd_wr_n), .i_addr(o_addr), .i_bus(i_data_in),
      .i_ld_n(o_output_load_strobe_n), .o_busy_n(i_busy_n), .o_oe(d_oe), .o_bus(d_bus), .o_out(q));
   // 25 MHz reference
   initial forever #20 i_ref_clk = ~i_ref_clk;
   task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] s);
      n_tests++;
      if (s !== e) begin
         num_errors++;
         $display("MISMATCH %s exp %h got %h", nm, e, s);
      end
   endtask
   // One access; returns with read data valid or the write finished
   task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge i_ref_clk);
      i_req <= '{w, a, d};
      i_req_valid <= 1'b1;
      for (int n = 0; n < 60 && o_cs_n !== 1'b0; n++) @(negedge i_ref_clk);
      chk("select fell", 14'h0000, DATA_W'(o_cs_n));
      @(posedge i_ref_clk);
      i_req_valid <= 1'b0;
      for (int n = 0; n < 8 && o_rd_valid !== 1'b1; n++) @(negedge i_ref_clk);
   endtask
   // Direct mode, two writes to one address back to back, then read
   task automatic t_async();
      acc(1'b1, 5'h03, 14'h1555);
      acc(1'b1, 5'h03, 14'h2A5C);
      chk("direct out", 14'h2A5C, q);
      acc(1'b0, 5'h03, 14'h0000);
      chk("read valid", 14'h0001, DATA_W'(o_rd_valid));
      chk("read data", 14'h2A5C, o_rd_data);
      $display("async test done");
   endtask
   // Strobe mode: output waits for the strobe, ready drops while the load runs
   task automatic t_sync();
      @(posedge i_ref_clk);
      i_sync_mode <= 1'b1;
      acc(1'b1, 5'h0B, 14'h1111);
      chk("held out", 14'h2A5C, q);
      @(posedge i_ref_clk);
      i_load_req <= 1'b1;
      @(posedge i_ref_clk);
      i_load_req <= 1'b0;
      repeat (2) @(negedge i_ref_clk);
      chk("ready in load", 14'h0000, DATA_W'(o_req_ready));
      for (int n = 0; n < 40 && o_load_done !== 1'b1; n++) @(negedge i_ref_clk);
      chk("load done", 14'h0001, DATA_W'(o_load_done));
      chk("loaded out", 14'h1111, q);
      @(negedge i_ref_clk);
      chk("ready after load", 14'h0001, DATA_W'(o_req_ready));
      $display("sync test done");
   endtask
   // Strobe asked together with a write must wait until that write's busy has ended
   task automatic t_busy_load();
      @(posedge i_ref_clk);
      i_req <= '{1'b1, 5'h0B, 14'h0222};
      i_req_valid <= 1'b1;
      i_load_req <= 1'b1;
      @(posedge i_ref_clk);
      i_load_req <= 1'b0;
      for (int n = 0; n < 60 && o_cs_n !== 1'b0; n++) @(negedge i_ref_clk);
      @(posedge i_ref_clk);
      i_req_valid <= 1'b0;
      for (int n = 0; n < 40 && o_output_load_strobe_n !== 1'b0; n++) @(negedge i_ref_clk);
      chk("busy at strobe", 14'h0001, DATA_W'(i_busy_n));
      for (int n = 0; n < 40 && o_load_done !== 1'b1; n++) @(negedge i_ref_clk);
      chk("load after busy", 14'h0222, q);
      $display("busy load test done");
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Watchdog far beyond the roughly eighty cycles needed
   initial begin
      #100000 num_errors++;
      complete_run();
   end
   initial begin
      repeat (16) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      repeat (4) @(posedge i_ref_clk);
      t_async();
      t_sync();
      t_busy_load();
      complete_run();
   end
endmodule
